// ---- rtl/orientation_detect_engine.sv ----
// Summary of operation
// - writing 0xCA to self-test register turns on actuation output
// - writing 0x00 to self-test register turns actuation off again
// - wake motion threshold resets to 0x08, a quarter g
// - orientation angle limit resets to 0x0C, about 22 degrees
// - hysteresis field sets rotation windows, default 15, up to 45 degrees
// - reported orientation is one of six states, changes are signalled
// - rotation windows use 0.5g and 0.866g limits at default hysteresis
// - between windows the reported rotation holds, giving hysteresis
// - below tilt limit, z sign picks face up or face down
// - rotation states chosen only while tilt exceeds the angle limit
// - angle limit compared against larger horizontal axis magnitude
// - new orientation accepted when sample count reaches qualify timer
// - each count is one sample period at the output sample rate
`default_nettype none

module orientation_detect_engine #(
  parameter logic [6:0] device_address = 7'h0f
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic sample_valid,
  input wire logic signed [7:0] accel_x,
  input wire logic signed [7:0] accel_y,
  input wire logic signed [7:0] accel_z,
  output logic self_test_drive,
  output logic [7:0] wake_motion_threshold,
  output logic operating_enable_bit,
  output logic [2:0] orientation,
  output logic orientation_changed
);

  typedef enum logic [3:0] {
    bus_idle, get_addr, ack_addr, get_ptr, ack_ptr,
    get_data, ack_data, send_data, ack_send
  } i2c_state_t;

  // ****************************************************
  // pin synchronisers, bit 0 scl, bit 1 sda
  // ****************************************************
  logic [1:0] pin_raw;
  logic [1:0] pin_q;
  logic [1:0] pin_prev_r;

  assign pin_raw = {sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic [2:0] sync_r;
      logic [2:0] sync_nxt;
      logic level_r;
      logic level_nxt;
      always_comb begin
        sync_nxt = {sync_r[1:0], pin_raw[gi]};
        // only agreeing later stages count, first stage never looked at
        level_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;
      end
      always_ff @(posedge clock) begin
        if (reset) begin
          sync_r <= 3'h7;
          level_r <= 1'b1;
        end else begin
          sync_r <= sync_nxt;
          level_r <= level_nxt;
        end
      end
      assign pin_q[gi] = level_r;
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_prev_r <= 2'h3;
    end else begin
      pin_prev_r <= pin_q;
    end
  end

  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_q = pin_q[0];
  assign sda_q = pin_q[1];
  assign scl_rise = scl_q & ~pin_prev_r[0];
  assign scl_fall = ~scl_q & pin_prev_r[0];
  assign bus_start = scl_q & pin_prev_r[0] & pin_prev_r[1] & ~sda_q;
  assign bus_stop = scl_q & pin_prev_r[0] & ~pin_prev_r[1] & sda_q;

  // ****************************************************
  // register file state
  // ****************************************************
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] qtimer_r;
  logic [7:0] qtimer_nxt;
  logic [7:0] st_r;
  logic [7:0] st_nxt;
  logic st_active_r;
  logic st_active_nxt;
  logic [7:0] wake_r;
  logic [7:0] wake_nxt;
  logic [7:0] tilt_r;
  logic [7:0] tilt_nxt;
  logic [7:0] hyst_r;
  logic [7:0] hyst_nxt;
  logic wr_en;

  orient_if link();

  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    unique case (addr)
      orient_pkg::status_addr:
        reg_read = {5'h00, 3'(link.reported)};
      orient_pkg::primary_control_register_addr: reg_read = ctrl_r;
      orient_pkg::qualify_timer_addr: reg_read = qtimer_r;
      orient_pkg::self_test_addr: reg_read = st_r;
      orient_pkg::wake_motion_threshold_addr: reg_read = wake_r;
      orient_pkg::orientation_angle_limit_addr: reg_read = tilt_r;
      orient_pkg::rotation_hysteresis_setting_addr: reg_read = hyst_r;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // ****************************************************
  // i2c slave
  // ****************************************************
  i2c_state_t state_r;
  i2c_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic rw_r;
  logic rw_nxt;
  logic drive_r;
  logic drive_nxt;
  logic nack_r;
  logic nack_nxt;
  logic [7:0] rd_byte;
  logic [7:0] rd_next;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    drive_nxt = drive_r;
    nack_nxt = nack_r;
    wr_en = 1'b0;
    rd_byte = reg_read(ptr_r);
    rd_next = reg_read(8'(ptr_r + 8'h01));
    if (bus_stop) begin
      state_nxt = bus_idle;
      drive_nxt = 1'b0;
    end else if (bus_start) begin
      state_nxt = get_addr;
      cnt_nxt = 4'h0;
      drive_nxt = 1'b0;
    end else if (scl_rise) begin
      unique case (state_r)
        get_addr, get_ptr, get_data: begin
          shift_nxt = {shift_r[6:0], sda_q};
          cnt_nxt = 4'(cnt_r + 4'h1);
        end
        send_data: cnt_nxt = 4'(cnt_r + 4'h1);
        ack_send: nack_nxt = sda_q;
        bus_idle, ack_addr, ack_ptr, ack_data: ;
      endcase
    end else if (scl_fall) begin
      unique case (state_r)
        bus_idle: ;
        get_addr: begin
          if (cnt_r == orient_pkg::bits_per_byte) begin
            cnt_nxt = 4'h0;
            if (shift_r[7:1] == device_address) begin
              state_nxt = ack_addr;
              rw_nxt = shift_r[0];
              drive_nxt = 1'b1;
            end else begin
              state_nxt = bus_idle;
            end
          end
        end
        ack_addr: begin
          if (rw_r) begin
            state_nxt = send_data;
            shift_nxt = rd_byte;
            drive_nxt = ~rd_byte[7];
          end else begin
            state_nxt = get_ptr;
            drive_nxt = 1'b0;
          end
        end
        get_ptr: begin
          if (cnt_r == orient_pkg::bits_per_byte) begin
            ptr_nxt = shift_r;
            cnt_nxt = 4'h0;
            state_nxt = ack_ptr;
            drive_nxt = 1'b1;
          end
        end
        ack_ptr: begin
          state_nxt = get_data;
          drive_nxt = 1'b0;
        end
        get_data: begin
          if (cnt_r == orient_pkg::bits_per_byte) begin
            wr_en = 1'b1;
            cnt_nxt = 4'h0;
            state_nxt = ack_data;
            drive_nxt = 1'b1;
          end
        end
        ack_data: begin
          ptr_nxt = 8'(ptr_r + 8'h01);
          state_nxt = get_data;
          drive_nxt = 1'b0;
        end
        send_data: begin
          if (cnt_r == orient_pkg::bits_per_byte) begin
            cnt_nxt = 4'h0;
            state_nxt = ack_send;
            drive_nxt = 1'b0;
          end else begin
            shift_nxt = {shift_r[6:0], 1'b0};
            drive_nxt = ~shift_r[6];
          end
        end
        ack_send: begin
          // pointer moves on even after nack so next read continues
          ptr_nxt = 8'(ptr_r + 8'h01);
          if (nack_r) begin
            state_nxt = bus_idle;
            drive_nxt = 1'b0;
          end else begin
            state_nxt = send_data;
            shift_nxt = rd_next;
            drive_nxt = ~rd_next[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= bus_idle;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      drive_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      drive_r <= drive_nxt;
      nack_r <= nack_nxt;
    end
  end

  // ****************************************************
  // register writes
  // ****************************************************
  // writes are not blocked while running; settings act on next sample
  always_comb begin
    ctrl_nxt = ctrl_r;
    qtimer_nxt = qtimer_r;
    st_nxt = st_r;
    st_active_nxt = st_active_r;
    wake_nxt = wake_r;
    tilt_nxt = tilt_r;
    hyst_nxt = hyst_r;
    if (wr_en) begin
      unique case (ptr_r)
        orient_pkg::primary_control_register_addr: ctrl_nxt = shift_r;
        orient_pkg::qualify_timer_addr: qtimer_nxt = shift_r;
        orient_pkg::self_test_addr: begin
          st_nxt = shift_r;
          if (shift_r == orient_pkg::self_test_on_code) begin
            st_active_nxt = 1'b1;
          end else if (shift_r == orient_pkg::self_test_off_code) begin
            st_active_nxt = 1'b0;
          end
        end
        orient_pkg::wake_motion_threshold_addr: wake_nxt = shift_r;
        orient_pkg::orientation_angle_limit_addr: tilt_nxt = shift_r;
        orient_pkg::rotation_hysteresis_setting_addr: hyst_nxt = shift_r;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r <= orient_pkg::primary_control_reset;
      qtimer_r <= orient_pkg::qualify_timer_reset;
      st_r <= orient_pkg::self_test_reset;
      st_active_r <= 1'b0;
      wake_r <= orient_pkg::wake_motion_threshold_reset;
      tilt_r <= orient_pkg::orientation_angle_limit_reset;
      hyst_r <= orient_pkg::rotation_hysteresis_setting_reset;
    end else begin
      ctrl_r <= ctrl_nxt;
      qtimer_r <= qtimer_nxt;
      st_r <= st_nxt;
      st_active_r <= st_active_nxt;
      wake_r <= wake_nxt;
      tilt_r <= tilt_nxt;
      hyst_r <= hyst_nxt;
    end
  end

  // ****************************************************
  // orientation engine
  // ****************************************************
  assign link.accel_x = accel_x;
  assign link.accel_y = accel_y;
  assign link.accel_z = accel_z;
  assign link.tilt_limit = tilt_r;
  assign link.hyst_field = hyst_r[orient_pkg::hysteresis_value_field_msb:0];
  assign link.qualify_limit = qtimer_r;
  assign link.sample_valid = sample_valid;
  assign link.run = ctrl_r[orient_pkg::operating_enable_bit_pos];

  orientation_classifier u_classifier (
    .link(link.cls)
  );

  orientation_qualifier u_qualifier (
    .clock(clock),
    .reset(reset),
    .link(link.qual)
  );

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_r;
  assign self_test_drive = st_active_r;
  assign wake_motion_threshold = wake_r;
  assign operating_enable_bit = ctrl_r[orient_pkg::operating_enable_bit_pos];
  assign orientation = 3'(link.reported);
  assign orientation_changed = link.changed;

endmodule

`default_nettype wire

// ---- include/orient_pkg.sv ----
`default_nettype none

package orient_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] status_addr = 8'h10;
  localparam logic [7:0] primary_control_register_addr = 8'h1b;
  localparam logic [7:0] qualify_timer_addr = 8'h28;
  localparam logic [7:0] self_test_addr = 8'h3a;
  localparam logic [7:0] wake_motion_threshold_addr = 8'h5a;
  localparam logic [7:0] orientation_angle_limit_addr = 8'h5c;
  localparam logic [7:0] rotation_hysteresis_setting_addr = 8'h5f;

  // ****************************************************
  // fields and values after reset
  // ****************************************************
  localparam int operating_enable_bit_pos = 7;
  localparam int hysteresis_value_field_msb = 4;
  localparam logic [7:0] primary_control_reset = 8'h00;
  localparam logic [7:0] qualify_timer_reset = 8'h00;
  localparam logic [7:0] self_test_reset = 8'h00;
  localparam logic [7:0] wake_motion_threshold_reset = 8'h08;
  localparam logic [7:0] orientation_angle_limit_reset = 8'h0c;
  localparam logic [7:0] rotation_hysteresis_setting_reset = 8'h14;
  localparam logic [7:0] self_test_on_code = 8'hca;
  localparam logic [7:0] self_test_off_code = 8'h00;
  localparam logic [3:0] bits_per_byte = 4'h8;

  // ****************************************************
  // orientation codes
  // ****************************************************
  typedef enum logic [2:0] {
    face_up, face_down, rot_0, rot_90, rot_180, rot_270
  } orient_t;

  // in-plane limits at 32 counts/g, indexed by hysteresis field
  // lo: off-axis magnitude must stay below; hi: on-axis must reach
  localparam logic [5:0] hyst_lo_tbl [32] = '{
    6'h17, 6'h16, 6'h16, 6'h16, 6'h15, 6'h15, 6'h15, 6'h14,
    6'h14, 6'h14, 6'h13, 6'h13, 6'h13, 6'h12, 6'h12, 6'h12,
    6'h11, 6'h11, 6'h11, 6'h10, 6'h10, 6'h0f, 6'h0d, 6'h0c,
    6'h0a, 6'h09, 6'h08, 6'h06, 6'h05, 6'h03, 6'h02, 6'h01};
  localparam logic [5:0] hyst_hi_tbl [32] = '{
    6'h17, 6'h17, 6'h17, 6'h17, 6'h18, 6'h18, 6'h18, 6'h19,
    6'h19, 6'h19, 6'h19, 6'h1a, 6'h1a, 6'h1a, 6'h1a, 6'h1b,
    6'h1b, 6'h1b, 6'h1b, 6'h1b, 6'h1c, 6'h1c, 6'h1d, 6'h1e,
    6'h1e, 6'h1f, 6'h1f, 6'h1f, 6'h20, 6'h20, 6'h20, 6'h20};

endpackage

`default_nettype wire

// ---- include/orient_if.sv ----
`default_nettype none

interface orient_if;
  logic signed [7:0] accel_x;
  logic signed [7:0] accel_y;
  logic signed [7:0] accel_z;
  logic [7:0] tilt_limit;
  logic [4:0] hyst_field;
  logic [7:0] qualify_limit;
  logic sample_valid;
  logic run;
  orient_pkg::orient_t candidate;
  orient_pkg::orient_t reported;
  logic changed;

  modport top (
    output accel_x, accel_y, accel_z, tilt_limit, hyst_field,
    output qualify_limit, sample_valid, run,
    input candidate, reported, changed
  );
  modport cls (
    input accel_x, accel_y, accel_z, tilt_limit, hyst_field, reported,
    output candidate
  );
  modport qual (
    input sample_valid, run, qualify_limit, candidate,
    output reported, changed
  );
endinterface

`default_nettype wire

// ---- rtl/orientation_classifier.sv ----
`default_nettype none

module orientation_classifier (
  orient_if.cls link
);

  // ****************************************************
  // magnitude helper
  // ****************************************************
  function automatic logic [7:0] mag8(input logic signed [7:0] v);
    mag8 = v[7] ? 8'(-v) : 8'(v);
  endfunction

  logic [7:0] ax;
  logic [7:0] ay;
  logic [7:0] horiz;
  logic [7:0] lo;
  logic [7:0] hi;

  // ****************************************************
  // sample classification
  // ****************************************************
  always_comb begin
    ax = mag8(link.accel_x);
    ay = mag8(link.accel_y);
    horiz = (ax > ay) ? ax : ay;
    lo = {2'b00, orient_pkg::hyst_lo_tbl[link.hyst_field]};
    hi = {2'b00, orient_pkg::hyst_hi_tbl[link.hyst_field]};
    if (horiz <= link.tilt_limit) begin
      // flat: screen direction unknowable, z sign decides
      link.candidate = link.accel_z[7] ? orient_pkg::face_down
                                       : orient_pkg::face_up;
    end else if (!link.accel_y[7] && ay >= hi && ax < lo) begin
      link.candidate = orient_pkg::rot_0;
    end else if (!link.accel_x[7] && ax >= hi && ay < lo) begin
      link.candidate = orient_pkg::rot_90;
    end else if (link.accel_y[7] && ay >= hi && ax < lo) begin
      link.candidate = orient_pkg::rot_180;
    end else if (link.accel_x[7] && ax >= hi && ay < lo) begin
      link.candidate = orient_pkg::rot_270;
    end else begin
      // between windows: hold, this is the hysteresis band
      link.candidate = link.reported;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/orientation_qualifier.sv ----
`default_nettype none

module orientation_qualifier (
  input wire logic clock,
  input wire logic reset,
  orient_if.qual link
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] count;
  orient_pkg::orient_t pend_r;
  orient_pkg::orient_t pend_nxt;
  orient_pkg::orient_t reported_r;
  orient_pkg::orient_t reported_nxt;
  logic changed_r;
  logic changed_nxt;

  // ****************************************************
  // qualification counter
  // ****************************************************
  always_comb begin
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    reported_nxt = reported_r;
    changed_nxt = 1'b0;
    count = 8'h00;
    if (!link.run) begin
      cnt_nxt = 8'h00;
    end else if (link.sample_valid) begin
      if (link.candidate == reported_r) begin
        cnt_nxt = 8'h00;
      end else begin
        // a different candidate restarts the count
        count = (link.candidate == pend_r && cnt_r != 8'h00)
              ? 8'(cnt_r + 8'h01) : 8'h01;
        pend_nxt = link.candidate;
        if (count >= link.qualify_limit) begin
          reported_nxt = link.candidate;
          changed_nxt = 1'b1;
          cnt_nxt = 8'h00;
        end else begin
          cnt_nxt = count;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_r <= 8'h00;
      pend_r <= orient_pkg::face_up;
      reported_r <= orient_pkg::face_up;
      changed_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
      reported_r <= reported_nxt;
      changed_r <= changed_nxt;
    end
  end

  assign link.reported = reported_r;
  assign link.changed = changed_r;

endmodule

`default_nettype wire

// ---- verif/orientation_detect_engine_assertions.sv ----
`default_nettype none

module orientation_detect_engine_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic sample_valid,
  input wire logic signed [7:0] accel_x,
  input wire logic signed [7:0] accel_y,
  input wire logic signed [7:0] accel_z,
  input wire logic self_test_drive,
  input wire logic [7:0] wake_motion_threshold,
  input wire logic operating_enable_bit,
  input wire logic [2:0] orientation,
  input wire logic orientation_changed
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************
  // axis magnitudes
  // ****************************************************
  logic [7:0] mag_x;
  logic [7:0] mag_y;
  assign mag_x = accel_x[7] ? 8'(-accel_x) : 8'(accel_x);
  assign mag_y = accel_y[7] ? 8'(-accel_y) : 8'(accel_y);

  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);

  // ****************************************************
  // checks
  // ****************************************************
  a_wake_reset: assert property (
    $fell(reset) |-> wake_motion_threshold == 8'h08 && !self_test_drive)
    else $error("wake threshold or self test wrong after reset");
  a_state_range: assert property (orientation <= 3'h5)
    else $error("orientation code outside six states");
  a_change_pulse: assert property (
    orientation_changed == (orientation != $past(orientation)))
    else $error("change pulse does not match orientation change");
  // either latency is accepted; samples are spaced wider than two cycles
  a_sample_paced: assert property (
    orientation_changed |-> $past(sample_valid) || $past(sample_valid, 2))
    else $error("orientation changed without a sample");
  a_enable_gate: assert property (
    sample_valid && !operating_enable_bit
      |-> ##1 !orientation_changed ##1 !orientation_changed)
    else $error("orientation changed while engine disabled");
  a_face_sign: assert property (
    orientation_changed && orientation <= 3'h1
      |-> (orientation == 3'h1) == $past(accel_z[7]))
    else $error("face state disagrees with z sign");
  // 8'h17 is the loosest window edge over every hysteresis setting
  a_rot_vertical: assert property (
    orientation_changed && (orientation == 3'h2 || orientation == 3'h4)
      |-> $past(accel_y[7]) == (orientation == 3'h4)
      && $past(mag_y) >= 8'h17 && $past(mag_x) < 8'h17)
    else $error("vertical rotation outside its window");
  a_rot_horizontal: assert property (
    orientation_changed && (orientation == 3'h3 || orientation == 3'h5)
      |-> $past(accel_x[7]) == (orientation == 3'h5)
      && $past(mag_x) >= 8'h17 && $past(mag_y) < 8'h17)
    else $error("horizontal rotation outside its window");
endmodule

`default_nettype wire

// ---- verif/host_i2c_model.sv ----
`default_nettype none

module host_i2c_model #(
  parameter logic [6:0] device_address = 7'h0f
) (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl_drive,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************
  // bit timing
  // ****************************************************
  // 12 clocks a half bit keeps clear of the 10 clock minimum
  localparam int half = 12;
  logic [6:0] target = device_address;

  initial begin
    scl_drive = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic put_bit(input logic b, output logic seen);
    sda_pull = !b;
    tick(half);
    scl_drive = 1'b1;
    tick(half);
    seen = sda_line;
    scl_drive = 1'b0;
    tick(2);
  endtask

  task automatic start();
    sda_pull = 1'b0;
    tick(half);
    scl_drive = 1'b1;
    tick(half);
    sda_pull = 1'b1;
    tick(half);
    scl_drive = 1'b0;
    tick(2);
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    tick(half);
    scl_drive = 1'b1;
    tick(half);
    sda_pull = 1'b0;
    tick(half);
  endtask

  // ****************************************************
  // byte and register transfers
  // ****************************************************
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], s);
    end
    put_bit(1'b1, s);
    ack = !s;
  endtask

  // single byte reads only, so the host always ends with a nack
  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(1'b1, s);
  endtask

  task automatic write_reg(input logic [7:0] a, d, output logic ok);
    logic k0, k1, k2;
    start();
    put_byte({target, 1'b0}, k0);
    put_byte(a, k1);
    put_byte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic k0, k1, k2;
    start();
    put_byte({target, 1'b0}, k0);
    put_byte(a, k1);
    start();
    put_byte({target, 1'b1}, k2);
    get_byte(d);
    stop();
  endtask
endmodule

`default_nettype wire

// ---- verif/orientation_detect_engine_tb.sv ----
`default_nettype none

module orientation_detect_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic sample_valid = 1'b0;
  logic signed [7:0] accel_x = 8'sh00;
  logic signed [7:0] accel_y = 8'sh00;
  logic signed [7:0] accel_z = 8'sh00;
  logic scl_drive, sda_pull, sda_line, sda_out, sda_oe_n;
  logic self_test_drive, operating_enable_bit, orientation_changed;
  logic [7:0] wake_motion_threshold;
  logic [2:0] orientation;
  int err_total = 0;
  int check_count = 0;
  int pulses = 0;
  int exp_pulses = 0;
  orient_pkg::orient_t last = orient_pkg::face_up;
  logic ok;

  always #10 clock = ~clock;
  // pull-up: high unless either party pulls low
  assign sda_line = !sda_pull && (sda_oe_n || sda_out);
  always @(posedge clock)
    if (orientation_changed === 1'b1)
      pulses <= pulses + 1;

  orientation_detect_engine DUT (
    .clock(clock), .reset(reset), .scl_in(scl_drive), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sample_valid(sample_valid),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .self_test_drive(self_test_drive),
    .wake_motion_threshold(wake_motion_threshold),
    .operating_enable_bit(operating_enable_bit),
    .orientation(orientation), .orientation_changed(orientation_changed)
  );
  host_i2c_model host (
    .clock(clock), .sda_line(sda_line), .scl_drive(scl_drive),
    .sda_pull(sda_pull)
  );

  // ****************************************************
  // compare and access tasks
  // ****************************************************
  task automatic check_byte(input string what, input logic [7:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_state(input string what,
    input orient_pkg::orient_t exp, input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, d);
    logic k;
    host.write_reg(a, d, k);
    check_byte("write ack", 8'h01, {7'h00, k});
  endtask

  task automatic rd(input logic [7:0] a, exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check_byte("read data", exp, d);
  endtask

  task automatic smp(input logic [7:0] x, y, z,
    input orient_pkg::orient_t exp);
    accel_x = x;
    accel_y = y;
    accel_z = z;
    sample_valid = 1'b1;
    @(posedge clock);
    #2;
    sample_valid = 1'b0;
    repeat (3) @(posedge clock);
    #2;
    if (exp != last)
      exp_pulses++;
    last = exp;
    check_state("orientation", exp, orientation);
    check_byte("change pulses", 8'(exp_pulses), 8'(pulses));
  endtask

  // ****************************************************
  // test sequence
  // ****************************************************
  initial begin
    repeat (12) @(posedge clock);
    #2;
    reset = 1'b0;
    repeat (6) @(posedge clock);
    #2;
    check_byte("wake output", 8'h08, wake_motion_threshold);
    rd(orient_pkg::wake_motion_threshold_addr, 8'h08);
    rd(orient_pkg::orientation_angle_limit_addr, 8'h0c);
    rd(orient_pkg::rotation_hysteresis_setting_addr, 8'h14);
    host.target = ~host.target;
    host.write_reg(orient_pkg::wake_motion_threshold_addr, 8'h33, ok);
    host.target = ~host.target;
    check_byte("foreign ack", 8'h00, {7'h00, ok});
    rd(8'h70, 8'h00);
    wr(orient_pkg::self_test_addr, 8'hca);
    check_byte("self test", 8'h01, {7'h00, self_test_drive});
    wr(orient_pkg::self_test_addr, 8'h00);
    check_byte("self test", 8'h00, {7'h00, self_test_drive});
    wr(orient_pkg::wake_motion_threshold_addr, 8'h20);
    check_byte("wake output", 8'h20, wake_motion_threshold);
    wr(orient_pkg::qualify_timer_addr, 8'h03);
    wr(orient_pkg::primary_control_register_addr, 8'h80);
    check_byte("enable bit", 8'h01, {7'h00, operating_enable_bit});
    repeat (2) smp(8'h00, 8'h00, 8'he0, orient_pkg::face_up);
    smp(8'h00, 8'h00, 8'he0, orient_pkg::face_down);
    repeat (2) smp(8'h1e, 8'h00, 8'h00, orient_pkg::face_down);
    smp(8'h00, 8'h00, 8'he0, orient_pkg::face_down);
    repeat (2) smp(8'h1e, 8'h00, 8'h00, orient_pkg::face_down);
    smp(8'h1e, 8'h00, 8'h00, orient_pkg::rot_90);
    repeat (3) smp(8'h14, 8'h1e, 8'h00, orient_pkg::rot_90);
    wr(orient_pkg::qualify_timer_addr, 8'h01);
    smp(8'h00, 8'h1b, 8'h00, orient_pkg::rot_90);
    smp(8'h00, 8'h1c, 8'h00, orient_pkg::rot_0);
    smp(8'he2, 8'h00, 8'h00, orient_pkg::rot_270);
    smp(8'h00, 8'he2, 8'h00, orient_pkg::rot_180);
    smp(8'h1e, 8'h00, 8'h00, orient_pkg::rot_90);
    wr(orient_pkg::primary_control_register_addr, 8'h00);
    wr(orient_pkg::orientation_angle_limit_addr, 8'h1f);
    rd(orient_pkg::orientation_angle_limit_addr, 8'h1f);
    wr(orient_pkg::rotation_hysteresis_setting_addr, 8'h1f);
    wr(orient_pkg::primary_control_register_addr, 8'h80);
    smp(8'h00, 8'he2, 8'h05, orient_pkg::face_up);
    smp(8'h00, 8'he0, 8'h05, orient_pkg::rot_180);
    smp(8'he0, 8'h02, 8'h00, orient_pkg::rot_180);
    wr(orient_pkg::primary_control_register_addr, 8'h00);
    smp(8'h00, 8'h00, 8'he0, orient_pkg::rot_180);
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    complete_run();
  end
endmodule

bind orientation_detect_engine orientation_detect_engine_checker watch (
  .clock(clock), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sample_valid(sample_valid),
  .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
  .self_test_drive(self_test_drive),
  .wake_motion_threshold(wake_motion_threshold),
  .operating_enable_bit(operating_enable_bit),
  .orientation(orientation), .orientation_changed(orientation_changed)
);

`default_nettype wire
